//--- design/bbc_pkg.sv
/*
 package for the backlight boost control block: register map, field
 layout, reset values, timing figures and the carried structs.
 assumes a 20 MHz system clock and a plain strobe register port.
*/
package bbc_pkg;
   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned OFF_TIME_NS  = 2_500_000;
   localparam int unsigned STEP_TIME_NS = 213_000;
   localparam int unsigned HALF_ILIM_NS = 5_000_000;
   localparam int unsigned SW_FREQ_HZ   = 600_000;
   localparam int unsigned NS_PER_S     = 1_000_000_000;
   // least times round up, the period rounds down
   localparam int unsigned OFF_CYC  =
      (OFF_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned STEP_CYC =
      (STEP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned HALF_CYC =
      (HALF_ILIM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SW_CYC   = CLK_HZ / SW_FREQ_HZ;
   localparam int unsigned SS_STEPS = 32;
   localparam int unsigned OVP_CNT  = 8;

   localparam int unsigned AW = 4;
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_REF    = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_EFF    = 4'h3;
   // control fields
   localparam int unsigned CTRL_BL_ON = 0;
   localparam int unsigned CTRL_SHUNT = 1;
   localparam int unsigned CTRL_VBUS  = 2;
   localparam logic [4:0] REF_RESET  = 5'h1F;

   typedef enum {
      BBC_OFF, BBC_SOFT, BBC_RUN, BBC_FAULT, BBC_OPEN
   } bbc_state_t;

   typedef struct packed {
      logic       uvlo;
      logic       tsd;
      logic       ovp;
      logic       fault;
   } bbc_sense_t;

   typedef struct packed {
      logic       active;
      logic       osc_on;
      logic       bias_on;
      logic       shunt_on;
      logic       drv_on;
      logic       sw_gate;
      logic       half_ilim;
      logic [4:0] ref_code;
      logic [7:0] ref_eff;
   } bbc_ana_t;
endpackage

//--- design/bbc_top.sv
/*
 backlight boost control: power state, enable arbitration, fault and
 lockout handling, soft start, open-led detection and dimming reference.
 assumes comparator inputs and the control pin are asynchronous and a
 host that holds the control pin low at power-up.
*/
// The address-and-strobe port and the address map are this design's own decisions.
// Operation
// - standby stops bias and oscillator, bus stays
// - active while vbus present or driver on
// - active keeps oscillator and reference running
// - pin edge or register bit enables driver
// - pin is edge sensitive, host holds low
// - register bit set masks the pin
// - pin low over 2.5 ms shuts down
// - reference from five-bit code, reset 200 mV
// - fault clears bit, waits pin low 2.5 ms
// - undervoltage stops switch, restarts on recovery
// - thermal trip switches off, self releases
// - soft start 32 steps of 213 us
// - half current limit for first 5 ms
// - eight overvoltage cycles shut driver down
// - after open-led need pin or bit toggle
// - constant high pin uses register code
// - pwm duty scales the reference
// - fixed 600 kHz switching, pwm switch
`timescale 1ns/1ps
`default_nettype none
module bbc_top #(
   parameter int unsigned OFF_CYCLES  = bbc_pkg::OFF_CYC,
   parameter int unsigned HALF_CYCLES = bbc_pkg::HALF_CYC,
   parameter int unsigned STEP_CYCLES = bbc_pkg::STEP_CYC,
   parameter int unsigned SW_CYCLES   = bbc_pkg::SW_CYC
) (
   input  wire logic                    i_clock,
   input  wire logic                    i_rst,
   input  wire logic                    i_ctrl_pin,
   input  wire logic                    i_vbus,
   input  wire bbc_pkg::bbc_sense_t     i_sense,
   input  wire logic [bbc_pkg::AW-1:0]  i_addr,
   input  wire logic [7:0]              i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic [7:0]                   o_rdata,
   output bbc_pkg::bbc_ana_t            o_ana
);
   typedef struct packed {
      logic [2:0]          pin_s;
      logic [2:0]          uv_s;
      logic [2:0]          ts_s;
      logic [2:0]          ov_s;
      logic [2:0]          fl_s;
      logic                pin_q;
      logic                uv_q;
      logic                ts_q;
      logic                ov_q;
      logic                fl_q;
      logic                bl_on;
      logic                shunt;
      logic [4:0]          ref_code;
      bbc_pkg::bbc_state_t st;
      logic [31:0]         low_cnt;
      logic [31:0]         step_cnt;
      logic [5:0]          step;
      logic [31:0]         half_cnt;
      logic [7:0]          sw_cnt;
      logic [3:0]          ovp_cnt;
      logic [15:0]         duty_hi;
      logic [15:0]         duty_all;
      logic [7:0]          ref_eff;
      logic [7:0]          rdata;
      bbc_pkg::bbc_ana_t   ana;
   } bbc_regs_t;

   bbc_regs_t r_reg;
   bbc_regs_t r_next;

   // a change counts once the second and third stages agree
   function automatic logic agreed(input logic [2:0] s, input logic q);
      agreed = (s[1] == s[2]) ? s[2] : q;
   endfunction

   logic pin;
   logic pin_rise;
   logic uv;
   logic ts;
   logic ov;
   logic fl;
   logic lockout;
   logic bl_rise;
   logic en_edge;
   logic drv;
   logic sw_tick;
   logic [7:0] scaled;

   always_comb
   begin
      r_next = r_reg;
      scaled = 8'h0;
      r_next.pin_s = {r_reg.pin_s[1:0], i_ctrl_pin};
      r_next.uv_s  = {r_reg.uv_s[1:0], i_sense.uvlo};
      r_next.ts_s  = {r_reg.ts_s[1:0], i_sense.tsd};
      r_next.ov_s  = {r_reg.ov_s[1:0], i_sense.ovp};
      r_next.fl_s  = {r_reg.fl_s[1:0], i_sense.fault};
      pin = agreed(r_reg.pin_s, r_reg.pin_q);
      uv  = agreed(r_reg.uv_s, r_reg.uv_q);
      ts  = agreed(r_reg.ts_s, r_reg.ts_q);
      ov  = agreed(r_reg.ov_s, r_reg.ov_q);
      fl  = agreed(r_reg.fl_s, r_reg.fl_q);
      r_next.pin_q = pin;
      r_next.uv_q  = uv;
      r_next.ts_q  = ts;
      r_next.ov_q  = ov;
      r_next.fl_q  = fl;
      pin_rise = pin & ~r_reg.pin_q;
      lockout = uv | ts;

      // register writes
      if (i_wr && i_addr == bbc_pkg::ADDR_CTRL)
      begin
         r_next.bl_on = i_wdata[bbc_pkg::CTRL_BL_ON];
         r_next.shunt = i_wdata[bbc_pkg::CTRL_SHUNT];
      end
      if (i_wr && i_addr == bbc_pkg::ADDR_REF)
      begin
         r_next.ref_code = i_wdata[4:0];
      end
      bl_rise = r_next.bl_on & ~r_reg.bl_on;
      en_edge = bl_rise || (!r_reg.bl_on && pin_rise);

      // low-time counter, restarted by any pin high
      if (pin)
      begin
         r_next.low_cnt = '0;
      end
      else if (r_reg.low_cnt <= OFF_CYCLES)
      begin
         r_next.low_cnt = r_reg.low_cnt + 32'h1;
      end

      // switching period tick
      sw_tick = (r_reg.sw_cnt == 8'(SW_CYCLES - 1));
      r_next.sw_cnt = sw_tick ? 8'h0 : r_reg.sw_cnt + 8'h1;

      case (r_reg.st)
         bbc_pkg::BBC_OFF:
         begin
            if (en_edge)
            begin
               r_next.st = bbc_pkg::BBC_SOFT;
            end
         end
         bbc_pkg::BBC_SOFT, bbc_pkg::BBC_RUN:
         begin
            if (fl)
            begin
               r_next.st = bbc_pkg::BBC_FAULT;
               r_next.bl_on = 1'b0;
               // low time counts from fault entry, so the state is held
               r_next.low_cnt = '0;
            end
            else if (r_reg.ovp_cnt == 4'(bbc_pkg::OVP_CNT))
            begin
               r_next.st = bbc_pkg::BBC_OPEN;
            end
            else if (!r_reg.bl_on && r_reg.low_cnt > OFF_CYCLES)
            begin
               r_next.st = bbc_pkg::BBC_OFF;
            end
            else if (r_reg.st == bbc_pkg::BBC_SOFT &&
                     r_reg.step == 6'(bbc_pkg::SS_STEPS))
            begin
               r_next.st = bbc_pkg::BBC_RUN;
            end
         end
         bbc_pkg::BBC_FAULT:
         begin
            r_next.bl_on = 1'b0;
            if (r_reg.low_cnt > OFF_CYCLES)
            begin
               r_next.st = bbc_pkg::BBC_OFF;
            end
         end
         bbc_pkg::BBC_OPEN:
         begin
            // a fresh enable edge; a bare clear would restart into shutdown
            if (en_edge)
            begin
               r_next.st = bbc_pkg::BBC_SOFT;
            end
         end
         default:
         begin
            r_next.st = bbc_pkg::BBC_OFF;
         end
      endcase

      drv = (r_reg.st == bbc_pkg::BBC_SOFT) ||
            (r_reg.st == bbc_pkg::BBC_RUN);

      // soft start restarts whenever the driver is not running
      if (!drv || lockout)
      begin
         r_next.step     = '0;
         r_next.step_cnt = '0;
         r_next.half_cnt = '0;
         r_next.ovp_cnt  = '0;
      end
      else
      begin
         if (r_reg.step < 6'(bbc_pkg::SS_STEPS))
         begin
            if (r_reg.step_cnt == STEP_CYCLES - 1)
            begin
               r_next.step_cnt = '0;
               r_next.step = r_reg.step + 6'h1;
            end
            else
            begin
               r_next.step_cnt = r_reg.step_cnt + 32'h1;
            end
         end
         if (r_reg.half_cnt < HALF_CYCLES)
         begin
            r_next.half_cnt = r_reg.half_cnt + 32'h1;
         end
         if (sw_tick)
         begin
            if (ov && r_reg.ovp_cnt < 4'(bbc_pkg::OVP_CNT))
            begin
               r_next.ovp_cnt = r_reg.ovp_cnt + 4'h1;
            end
            else if (!ov)
            begin
               r_next.ovp_cnt = '0;
            end
         end
      end

      // duty measure over the switching window, pin chops the code
      if (sw_tick)
      begin
         r_next.duty_hi  = '0;
         r_next.duty_all = '0;
         scaled = 8'((r_reg.duty_hi * 16'(r_reg.ref_code) * 16'h8) /
                     ((r_reg.duty_all == 16'h0) ? 16'h1 : r_reg.duty_all));
         // filtered: first-order step halfway toward the chopped level
         r_next.ref_eff = 8'((9'(r_reg.ref_eff) + 9'(scaled)) >> 1);
      end
      else
      begin
         r_next.duty_hi  = r_reg.duty_hi + {15'h0, pin};
         r_next.duty_all = r_reg.duty_all + 16'h1;
      end

      // analog-facing controls
      r_next.ana.drv_on    = drv && !lockout;
      r_next.ana.active    = i_vbus || drv;
      r_next.ana.osc_on    = r_next.ana.active;
      r_next.ana.bias_on   = r_next.ana.active;
      r_next.ana.shunt_on  = r_reg.shunt;
      r_next.ana.sw_gate   = drv && !lockout && !ov &&
                             (r_reg.sw_cnt < 8'(SW_CYCLES / 2));
      r_next.ana.half_ilim = drv && (r_reg.half_cnt < HALF_CYCLES);
      r_next.ana.ref_code  = (r_reg.step < 6'(bbc_pkg::SS_STEPS)) ?
         5'((11'(r_reg.ref_code) * 11'(r_reg.step)) >> 5) :
         r_reg.ref_code;
      r_next.ana.ref_eff   = r_reg.ref_eff;

      // read port, data in the following cycle only
      r_next.rdata = 8'h0;
      if (i_rd)
      begin
         case (i_addr)
            bbc_pkg::ADDR_CTRL:
               r_next.rdata = {5'h0, i_vbus, r_reg.shunt, r_reg.bl_on};
            bbc_pkg::ADDR_REF:    r_next.rdata = {3'h0, r_reg.ref_code};
            bbc_pkg::ADDR_STATUS:
               r_next.rdata = {uv, ts, r_reg.ana.active, 2'h0,
                               3'(r_reg.st)};
            bbc_pkg::ADDR_EFF:    r_next.rdata = r_reg.ref_eff;
            default:              r_next.rdata = 8'h0;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         r_reg          <= '0;
         r_reg.st       <= bbc_pkg::BBC_OFF;
         r_reg.ref_code <= bbc_pkg::REF_RESET;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign o_rdata = r_reg.rdata;
   assign o_ana   = r_reg.ana;
endmodule
`default_nettype wire

//--- verif/bbc_host.sv
/*
 host side model of the brightness control pin: level or 50 percent pwm.
 assumes the bench selects the mode; a period of 40 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module bbc_host (
   input  wire logic i_clock,
   input  wire logic i_rst,
   input  wire logic i_level,
   input  wire logic i_pwm,
   output var  logic o_ctrl_pin
);
   logic [5:0] cnt_reg;
   always_ff @(posedge i_clock)
   begin
      cnt_reg <= (i_rst || cnt_reg == 6'h27) ? 6'h00 : cnt_reg + 6'h01;
      if (i_rst)
         o_ctrl_pin <= 1'b0;
      else
         o_ctrl_pin <= i_pwm ? (cnt_reg < 6'h14) : i_level;
   end
endmodule
`default_nettype wire

//--- verif/bbc_top_properties.sv
/*
 checker for the backlight boost control top ports.
 assumes a bind into bbc_top and the register port timing of the notes.
*/
`timescale 1ns/1ps
`default_nettype none
module bbc_top_chk (
   input  wire logic                i_clock,
   input  wire logic                i_rst,
   input  wire bbc_pkg::bbc_sense_t i_sense,
   input  wire logic                i_rd,
   input  wire logic [7:0]          o_rdata,
   input  wire bbc_pkg::bbc_ana_t   o_ana
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   chk_standby_dark: assert property (
      !o_ana.active |-> !o_ana.osc_on && !o_ana.bias_on)
      else $error("oscillator or bias on in standby");
   chk_active_osc: assert property (
      o_ana.active |-> o_ana.osc_on && o_ana.bias_on)
      else $error("oscillator or bias off while active");
   chk_drv_active: assert property (
      o_ana.drv_on |-> o_ana.active)
      else $error("driver on outside active state");
   chk_gate_drv: assert property (
      o_ana.sw_gate |-> o_ana.drv_on)
      else $error("switch gated while driver off");
   chk_uvlo_blank: assert property (
      i_sense.uvlo [*6] |-> !o_ana.sw_gate && !o_ana.drv_on)
      else $error("driver running under undervoltage");
   chk_tsd_blank: assert property (
      i_sense.tsd [*6] |-> !o_ana.sw_gate && !o_ana.drv_on)
      else $error("driver running under thermal trip");
   chk_fault_off: assert property (
      i_sense.fault [*6] |-> !o_ana.drv_on)
      else $error("driver running during fault");
   chk_rdata_idle: assert property (
      !$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule
bind bbc_top bbc_top_chk i_chk (
   .i_clock (i_clock),
   .i_rst   (i_rst),
   .i_sense (i_sense),
   .i_rd    (i_rd),
   .o_rdata (o_rdata),
   .o_ana   (o_ana)
);
`default_nettype wire

//--- verif/testbench.sv
/*
 self-checking bench for the backlight boost control block.
 assumes short timing parameters; host model drives the control pin.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
   end end
module testbench;
   localparam int OFF = 50;
   logic               i_clock = 0, i_rst = 1, i_vbus = 0, i_wr = 0;
   logic               i_rd = 0, pin = 0, lvl = 0, pwm = 0;
   logic [3:0]         i_addr = '0;
   logic [7:0]         i_wdata = '0, o_rdata, d;
   bbc_pkg::bbc_sense_t i_sense = '0;
   bbc_pkg::bbc_ana_t  o_ana;
   int                 n_mismatch = 0, num_checks = 0;
   always #25 i_clock = ~i_clock;
   bbc_host i_host (.i_clock(i_clock), .i_rst(i_rst), .i_level(lvl),
      .i_pwm(pwm), .o_ctrl_pin(pin));
   bbc_top #(.OFF_CYCLES(OFF), .HALF_CYCLES(100), .STEP_CYCLES(4),
      .SW_CYCLES(33)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_ctrl_pin(pin), .i_vbus(i_vbus), .i_sense(i_sense),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_ana(o_ana));
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // bounded wait; running out ends the run as a mismatch
   task automatic wait_drv(input logic v, input int n);
      int k;
      k = 0;
      while (o_ana.drv_on !== v && k < n)
      begin
         cyc(1);
         k++;
      end
      `CHK("drv_on", v, o_ana.drv_on)
      if (o_ana.drv_on !== v) wrap_up();
   endtask
   initial
   begin
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      cyc(2);
      rd(bbc_pkg::ADDR_REF, d); `CHK("ref reset", 8'h1F, d)
      rd(4'hF, d); `CHK("unmapped", 8'h00, d)
      `CHK("standby", 1'b0, o_ana.active)
      i_vbus <= 1'b1;
      cyc(3); `CHK("vbus active", 1'b1, o_ana.active)
      rd(bbc_pkg::ADDR_CTRL, d); `CHK("ctrl vbus", 8'h04, d)
      i_vbus <= 1'b0;
      wr(bbc_pkg::ADDR_CTRL, 8'h02);
      cyc(2);
      `CHK("shunt on", 1'b1, o_ana.shunt_on)
      `CHK("standby again", 1'b0, o_ana.active)
      $display("test power done");
      wr(bbc_pkg::ADDR_CTRL, 8'h01); wait_drv(1'b1, 20);
      `CHK("osc", 1'b1, o_ana.osc_on)
      `CHK("shunt off", 1'b0, o_ana.shunt_on)
      `CHK("half limit", 1'b1, o_ana.half_ilim)
      cyc(140); `CHK("ramp end", 5'h1F, o_ana.ref_code)
      cyc(OFF + 20); `CHK("bit masks pin", 1'b1, o_ana.drv_on)
      `CHK("full limit", 1'b0, o_ana.half_ilim)
      i_sense <= 4'h1; wait_drv(1'b0, 20);
      cyc(4);
      i_sense <= 4'h0;
      rd(bbc_pkg::ADDR_CTRL, d); `CHK("bit cleared", 8'h00, d)
      rd(bbc_pkg::ADDR_STATUS, d); `CHK("fault", 3'h3, d[2:0])
      cyc(OFF + 20);
      rd(bbc_pkg::ADDR_STATUS, d); `CHK("left fault", 3'h0, d[2:0])
      $display("test register enable and fault done");
      lvl <= 1'b1; wait_drv(1'b1, 20);
      cyc(200); `CHK("pin high ref", 5'h1F, o_ana.ref_code)
      wr(bbc_pkg::ADDR_REF, 8'h0A);
      cyc(3); `CHK("ref code", 5'h0A, o_ana.ref_code)
      cyc(400);
      rd(bbc_pkg::ADDR_EFF, d); `CHK("full eff", 8'h50, d)
      pwm <= 1'b1;
      cyc(3000); `CHK("pwm keeps on", 1'b1, o_ana.drv_on)
      d = o_ana.ref_eff;
      `CHK("pwm eff", 1'b1, d > 8'h14 && d < 8'h3C)
      pwm <= 1'b0;
      cyc(5);
      lvl <= 1'b0;
      cyc(OFF - 10); `CHK("not yet off", 1'b1, o_ana.drv_on)
      wait_drv(1'b0, 40);
      $display("test pin control done");
      wr(bbc_pkg::ADDR_CTRL, 8'h01); wait_drv(1'b1, 20);
      for (int j = 0; j < 2; j++)
      begin
         i_sense <= (j == 0) ? 4'h8 : 4'h4;
         wait_drv(1'b0, 20);
         `CHK("gate off", 1'b0, o_ana.sw_gate)
         cyc(6);
         i_sense <= 4'h0;
         wait_drv(1'b1, 20);
         `CHK("ramp restart", 1'b1, o_ana.ref_code < 5'h0A)
      end
      $display("test lockout done");
      i_sense <= 4'h2;
      cyc(198); `CHK("ovp early", 1'b1, o_ana.drv_on)
      wait_drv(1'b0, 200);
      rd(bbc_pkg::ADDR_STATUS, d); `CHK("open", 3'h4, d[2:0])
      i_sense <= 4'h0;
      cyc(OFF + 20); `CHK("stays off", 1'b0, o_ana.drv_on)
      wr(bbc_pkg::ADDR_CTRL, 8'h00);
      wr(bbc_pkg::ADDR_CTRL, 8'h01); wait_drv(1'b1, 20);
      cyc(OFF + 20); `CHK("stays on", 1'b1, o_ana.drv_on)
      $display("test open led done");
      wrap_up();
   end
endmodule
`default_nettype wire
